// ==== hdl/plsr_regs.v ====
// link control/status and uncorrectable error reporting register bank
// Operation
// - two-bit power-state entry field, 00 none, 01 L0s, 10 L1, 11 both
// - receiver may always enter L0s, even with entry disabled
// - completion boundary, link disable, retrain, slot clock read zero
// - common clock bit, read-write, resets to zero
// - extended synch picks 4096 FTS or 1024 TS1 on exit to L0
// - link speed in status bits 19:16, reads 0001b
// - negotiated width in status bits 25:20
// - training error bit set on failure, cleared on successful L0
// - link training bit high while training in progress
// - capability identifier 0001h in header bits 15:0
// - capability version 1h in header bits 19:16
// - next capability pointer zero in header bits 31:20
// - status bits 0 and 4 sticky, write-one-to-clear, reset zero
// - status bit 12 set on poisoned TLP received or generated
// - bits 13, 14, 15 on flow control, timeout, completer abort
// - bit 16 unexpected completion, bit 17 receiver overflow
// - bits 18, 19, 20 on malformed TLP, ECRC error, unsupported request
// - masked errors still logged but not signalled or header logged
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "plsr_consts.vh"

module plsr_regs #(
  parameter ADDR_W = 12,
  parameter WIDTH_W = 6
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // link training state from the physical layer, async to pclk
  input wire train_active,
  input wire train_fail,
  input wire train_ok_l0,
  input wire [WIDTH_W-1:0] link_width,
  // one-cycle error events on pclk, order matches status bits 0,4,12..20
  input wire [10:0] err_event,
  // power management controls to the link layer
  output reg aspm_l0s_en,
  output reg aspm_l1_en,
  output reg rx_l0s_allowed,
  output reg common_clk,
  output reg [12:0] fts_count,
  output reg [12:0] ts1_count,
  // error message request and header log strobe, one cycle each
  output reg err_msg,
  output reg hdr_log,
  output reg irq
);

  // apb access phase; zero wait states
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;

  // three-stage pin synchronisers; stage 1 read only by stage 2
  reg [2:0] act_s1_reg, act_s2_reg, act_s3_reg;
  reg [WIDTH_W-1:0] w_s1_reg, w_s2_reg, w_s3_reg;
  reg [WIDTH_W-1:0] width_reg;
  reg act_reg, fail_reg, okl0_reg;
  reg act_q_reg, fail_q_reg, ok_q_reg;
  wire [2:0] pins = {train_active, train_fail, train_ok_l0};

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      act_s1_reg <= 3'h0;
      act_s2_reg <= 3'h0;
      act_s3_reg <= 3'h0;
      w_s1_reg <= {WIDTH_W{1'b0}};
      w_s2_reg <= {WIDTH_W{1'b0}};
      w_s3_reg <= {WIDTH_W{1'b0}};
    end
    else
    begin
      act_s1_reg <= pins;
      act_s2_reg <= act_s1_reg;
      act_s3_reg <= act_s2_reg;
      w_s1_reg <= link_width;
      w_s2_reg <= w_s1_reg;
      w_s3_reg <= w_s2_reg;
    end
  end

  // filtered levels: change accepted when stages 2 and 3 agree
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      act_reg <= 1'b0;
      fail_reg <= 1'b0;
      okl0_reg <= 1'b0;
      width_reg <= `PLSR_WIDTH_RST;
      act_q_reg <= 1'b0;
      fail_q_reg <= 1'b0;
      ok_q_reg <= 1'b0;
    end
    else
    begin
      if (act_s2_reg[2] == act_s3_reg[2])
        act_reg <= act_s3_reg[2];
      if (act_s2_reg[1] == act_s3_reg[1])
        fail_reg <= act_s3_reg[1];
      if (act_s2_reg[0] == act_s3_reg[0])
        okl0_reg <= act_s3_reg[0];
      if (w_s2_reg == w_s3_reg)
        width_reg <= w_s3_reg;
      act_q_reg <= act_reg;
      fail_q_reg <= fail_reg;
      ok_q_reg <= okl0_reg;
    end
  end

  wire fail_rise = fail_reg & ~fail_q_reg;
  wire ok_rise = okl0_reg & ~ok_q_reg;
  wire done_fall = act_q_reg & ~act_reg;

  // link control storage
  reg [1:0] aspm_reg;
  reg cclk_reg, xsync_reg;
  reg terr_reg;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      aspm_reg <= `PLSR_ASPM_RST;
      cclk_reg <= 1'b0;
      xsync_reg <= 1'b0;
    end
    else if (wr && paddr == `PLSR_ADDR_LINK && pstrb[0])
    begin
      aspm_reg <= pwdata[`PLSR_ASPM_MSB:`PLSR_ASPM_LSB];
      cclk_reg <= pwdata[`PLSR_CCLK_BIT];
      xsync_reg <= pwdata[`PLSR_XSYNC_BIT];
    end
  end

  // training error: failure sets, success into L0 clears; failure wins
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      terr_reg <= 1'b0;
    else if (fail_rise)
      terr_reg <= 1'b1;
    else if (ok_rise)
      terr_reg <= 1'b0;
  end

  // uncorrectable status and mask, packed into full word layout
  reg [31:0] uncor_reg, umask_reg;
  wire [31:0] ev_word = {11'h000, err_event[10:2], 7'h00,
                         err_event[1], 3'h0, err_event[0]};
  wire [31:0] w1c = (wr && paddr == `PLSR_ADDR_UNCOR) ?
    ({{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}}
     & pwdata) : 32'h00000000;

  // set wins over write-one-to-clear in the same cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      uncor_reg <= 32'h00000000;
    else
      uncor_reg <= ((uncor_reg & ~w1c) | ev_word)
                   & `PLSR_UNCOR_IMPL;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      umask_reg <= 32'h00000000;
    else if (wr && paddr == `PLSR_ADDR_UNCOR_MASK)
      umask_reg <= pwdata & `PLSR_UNCOR_IMPL;
  end

  // unmasked events signal; masked ones are only recorded
  wire sig_any = |(ev_word & ~umask_reg);

  // interrupt status, cleared by read; set wins over the read clear
  reg [`PLSR_INT_NUM-1:0] ist_reg, imask_reg;
  wire [`PLSR_INT_NUM-1:0] iev = {done_fall, fail_rise, sig_any};
  wire ird = rd && paddr == `PLSR_ADDR_INT_STAT;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ist_reg <= {`PLSR_INT_NUM{1'b0}};
      imask_reg <= {`PLSR_INT_NUM{1'b0}};
    end
    else
    begin
      ist_reg <= (ird ? {`PLSR_INT_NUM{1'b0}} : ist_reg) | iev;
      if (wr && paddr == `PLSR_ADDR_INT_MASK)
        imask_reg <= pwdata[`PLSR_INT_NUM-1:0];
    end
  end

  // read mux; reserved and hardwired bits are zero
  reg [31:0] rdata;
  reg hit;
  always @*
  begin
    rdata = 32'h00000000;
    hit = 1'b1;
    case (paddr)
      `PLSR_ADDR_LINK:
        rdata = {4'h0, act_reg, terr_reg,
                 width_reg, `PLSR_SPEED_2G5,
                 8'h00, xsync_reg, cclk_reg, 3'h0, 1'b0, aspm_reg};
      `PLSR_ADDR_AER_HDR:
        rdata = {`PLSR_CAP_NEXT, `PLSR_CAP_VER,
                 `PLSR_CAP_ID};
      `PLSR_ADDR_UNCOR: rdata = uncor_reg;
      `PLSR_ADDR_UNCOR_MASK: rdata = umask_reg;
      `PLSR_ADDR_INT_STAT: rdata = {29'h00000000, ist_reg};
      `PLSR_ADDR_INT_MASK: rdata = {29'h00000000, imask_reg};
      default: hit = 1'b0;
    endcase
  end

  // apb answer registered: pready in the access cycle's next edge
  // would stretch every access, so setup-cycle decode is used instead
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit;
      prdata <= (psel & ~penable & ~pwrite) ? rdata : 32'h00000000;
    end
  end

  // link-layer controls, all registered
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      aspm_l0s_en <= 1'b0;
      aspm_l1_en <= 1'b0;
      rx_l0s_allowed <= 1'b1;
      common_clk <= 1'b0;
      fts_count <= `PLSR_FTS_NORM;
      ts1_count <= `PLSR_TS1_NORM;
      err_msg <= 1'b0;
      hdr_log <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      aspm_l0s_en <= aspm_reg[`PLSR_ASPM_L0S_BIT];
      aspm_l1_en <= aspm_reg[`PLSR_ASPM_L1_BIT];
      rx_l0s_allowed <= 1'b1;
      common_clk <= cclk_reg;
      fts_count <= xsync_reg ? `PLSR_FTS_EXT : `PLSR_FTS_NORM;
      ts1_count <= xsync_reg ? `PLSR_TS1_EXT : `PLSR_TS1_NORM;
      err_msg <= sig_any;
      hdr_log <= sig_any;
      irq <= |(((ird ? {`PLSR_INT_NUM{1'b0}} : ist_reg) | iev)
               & imask_reg);
    end
  end

endmodule // plsr_regs
`default_nettype wire

// ==== common/plsr_consts.vh ====
// constants for the link control, link status and error reporting registers
`ifndef PLSR_CONSTS_VH
`define PLSR_CONSTS_VH
// byte addresses of the register words
`define PLSR_ADDR_LINK 12'h0F0
`define PLSR_ADDR_AER_HDR 12'h100
`define PLSR_ADDR_UNCOR 12'h104
`define PLSR_ADDR_UNCOR_MASK 12'h108
`define PLSR_ADDR_INT_STAT 12'h110
`define PLSR_ADDR_INT_MASK 12'h114
// link control fields
`define PLSR_ASPM_LSB 0
`define PLSR_ASPM_MSB 1
`define PLSR_CCLK_BIT 6
`define PLSR_XSYNC_BIT 7
`define PLSR_ASPM_RST 2'h0
`define PLSR_ASPM_L0S_BIT 0
`define PLSR_ASPM_L1_BIT 1
// link status fields (upper half of the word)
`define PLSR_SPEED_2G5 4'h1
`define PLSR_WIDTH_RST 6'h01
// error reporting header
`define PLSR_CAP_ID 16'h0001
`define PLSR_CAP_VER 4'h1
`define PLSR_CAP_NEXT 12'h000
// implemented uncorrectable bits: 0,4,12..20
`define PLSR_UNCOR_IMPL 32'h001FF011
`define PLSR_UNCOR_NUM 11
// interrupt events: 0 unmasked error signalled, 1 training error, 2 training done
`define PLSR_INT_NUM 3
// ordered set counts for extended synch
`define PLSR_FTS_EXT 13'h1000
`define PLSR_TS1_EXT 13'h0400
`define PLSR_FTS_NORM 13'h0080
`define PLSR_TS1_NORM 13'h0010
`endif

// ==== dv/plsr_phy_model.sv ====
// far-side error source: one-cycle detector pulses on pclk
`timescale 1ns/1ps
`default_nettype none
module plsr_phy_model (
  input wire logic pclk,
  input wire logic fire,
  input wire logic [3:0] idx,
  output logic [10:0] err_event
);
  // registered like the real detectors, so pulses never span two edges
  initial err_event = 11'h000;
  always @(posedge pclk)
    err_event <= fire ? 11'h001 << idx : 11'h000;
endmodule // plsr_phy_model
`default_nettype wire

// ==== dv/plsr_regs_monitor.sv ====
// assertion checker for the link and error register bank
`timescale 1ns/1ps
`default_nettype none
module plsr_monitor #(parameter ADDR_W = 12) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [10:0] err_event,
  input wire logic rx_l0s_allowed,
  input wire logic aspm_l0s_en,
  input wire logic [12:0] fts_count,
  input wire logic err_msg,
  input wire logic hdr_log
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // decoded read answer and low-lane write at the access edge
  wire rd_hit = pready && !pwrite;
  wire wr_lo = psel && penable && pwrite && pstrb[0];
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  zero_wait_a: assert property (s_setup |=> s_answer)
    else $error("ready not one cycle after setup");
  idle_data_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  hdr_value_a: assert property (rd_hit && paddr == 12'h100 |->
    prdata == 32'h00010001) else $error("bad capability header");
  l0s_kept_a: assert property (rx_l0s_allowed)
    else $error("receiver l0s blocked");
  ro_bits_a: assert property (rd_hit && paddr == 12'h0F0 |->
    (prdata & 32'hF000FF3C) == 32'h0) else $error("link ro bits set");
  rsvd_stat_a: assert property (rd_hit && paddr == 12'h104 |->
    (prdata & 32'hFFE00FEE) == 32'h0) else $error("status rsvd set");
  ctrl_write_a: assert property (wr_lo && paddr == 12'h0F0 |-> ##2
    aspm_l0s_en == $past(pwdata[0], 2) &&
    fts_count == ($past(pwdata[7], 2) ? 13'h1000 : 13'h0080))
    else $error("link control write lost");
  msg_pair_a: assert property (err_msg |-> hdr_log &&
    $past(err_event) != 11'h0) else $error("message without event");
  slverr_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error answer malformed");
endmodule // plsr_monitor
bind plsr_regs plsr_monitor #(.ADDR_W(ADDR_W)) u_mon (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .err_event(err_event),
  .rx_l0s_allowed(rx_l0s_allowed), .aspm_l0s_en(aspm_l0s_en),
  .fts_count(fts_count), .err_msg(err_msg), .hdr_log(hdr_log));
`default_nettype wire

// ==== dv/pcie_link_ctrl_status_aer_regs_test.sv ====
// self-checking bench for the link and error register bank
`timescale 1ns/1ps
`default_nettype none
module pcie_link_ctrl_status_aer_regs_test;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic train_active = 0, train_fail = 0, train_ok_l0 = 0, fire = 0;
  logic pready, pslverr, se, l0s_en, l1_en, l0s_ok, cclk, msg, irq;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rv;
  logic [3:0] pstrb = 4'hF, idx = 0;
  logic [5:0] link_width = 6'h04;
  logic [10:0] err_event;
  logic [12:0] fts, ts1;
  int n_mismatch = 0, tests_run = 0, n_msg = 0;
  initial forever #25 pclk = ~pclk;
  // count message pulses to show masking suppresses them
  always @(posedge pclk) n_msg <= n_msg + msg;
  plsr_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .train_active(train_active), .train_fail(train_fail),
    .train_ok_l0(train_ok_l0), .link_width(link_width),
    .err_event(err_event), .aspm_l0s_en(l0s_en), .aspm_l1_en(l1_en),
    .rx_l0s_allowed(l0s_ok), .common_clk(cclk), .fts_count(fts),
    .ts1_count(ts1), .err_msg(msg), .hdr_log(), .irq(irq));
  plsr_phy_model u_phy (.pclk(pclk), .fire(fire), .idx(idx),
    .err_event(err_event));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; request held until pready seen at an edge
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed; only the watchdog ends a hung wait
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rv = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rv, e);
  endtask
  // pulse one event through the model, then let it land
  task automatic ev(input logic [3:0] i);
    idx <= i;
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    #1000000;
    n_mismatch++;
    final_report;
  end
  initial
  begin
    logic [31:0] b;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk); // width pins pass a synchroniser
    rd(12'h0F0, 32'h00410000);
    rd(12'h100, 32'h00010001);
    rd(12'h104, 32'h0);
    apb(1'b1, 12'h0F0, 32'hFFFFFFFF);
    rd(12'h0F0, 32'h004100C3);
    chk({cclk, fts, ts1}, {1'b1, 13'h1000, 13'h0400});
    for (int m = 0; m < 4; m++)
    begin
      apb(1'b1, 12'h0F0, m);
      @(posedge pclk); // outputs lag the register by one edge
      chk({l1_en, l0s_en, l0s_ok, fts}, {m[1:0], 1'b1, 13'h0080});
    end
    $display("link control test done");
    train_active <= 1'b1;
    repeat (8) @(posedge pclk);
    rd(12'h0F0, 32'h08410003);
    train_fail <= 1'b1;
    repeat (8) @(posedge pclk);
    rd(12'h0F0, 32'h0C410003);
    train_active <= 1'b0;
    train_fail <= 1'b0;
    train_ok_l0 <= 1'b1;
    repeat (8) @(posedge pclk);
    rd(12'h0F0, 32'h00410003);
    chk(irq, 1'b0);
    rd(12'h110, 32'h6);
    $display("training test done");
    apb(1'b1, 12'h114, 32'h1);
    // walk every event source: set, clear by one, read back empty
    for (int i = 0; i < 11; i++)
    begin
      b = 32'h1 << (i == 0 ? 0 : i == 1 ? 4 : i + 10);
      ev(i);
      rd(12'h104, b);
      apb(1'b1, 12'h104, b);
      rd(12'h104, 32'h0);
    end
    chk(irq, 1'b1);
    rd(12'h110, 32'h1);
    chk({31'h0, irq}, 32'h0);
    chk(n_msg, 32'hB);
    apb(1'b1, 12'h108, 32'h001FF011);
    ev(2);
    rd(12'h104, 32'h1000);
    rd(12'h110, 32'h0);
    chk({31'h0, irq}, 32'h0);
    chk(n_msg, 32'hB);
    // reset in mid-run clears the sticky status left by the masked event
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(12'h104, 32'h0);
    apb(1'b0, 12'h200, 32'h0);
    chk({31'h0, se}, 32'h1);
    chk(rv, 32'h0);
    $display("error status test done");
    final_report;
  end
endmodule // pcie_link_ctrl_status_aer_regs_test
`default_nettype wire
